// [rtl/mem_err_regs.svh]
// Purpose: Register offsets, field masks and reset values of the memory error block
// Assumes: Byte addresses on a 16-bit Avalon-MM address, one aligned word per register
// Notes: Definitions only, included by the package
`ifndef MEM_ERR_REGS_SVH
`define MEM_ERR_REGS_SVH

// ==========================================================
// Widths
// ==========================================================
`define ME_AW 16
`define ME_DW 32
`define ME_FAT_W 4
`define ME_DESC_W 13
`define ME_PP_W 15
`define ME_IRQ_W 5
`define ME_CNT_W 8

// ==========================================================
// Register byte offsets
// ==========================================================
`define ME_FATAL_FLAGS_OFS 16'h1084
`define ME_FATAL_MASK_OFS 16'h1088
`define ME_IRQ_STATUS_OFS 16'h1090
`define ME_IRQ_MASK_OFS 16'h1094
`define ME_RX_PB_ECC_OFS 16'h245c
`define ME_TX_PB_ECC_OFS 16'h345c
`define ME_TXD_PAR_CTL_OFS 16'h3500
`define ME_RXD_PAR_CTL_OFS 16'h3504
`define ME_HD_PAR_CTL_OFS 16'h3508
`define ME_TXD_PAR_STS_OFS 16'h3510
`define ME_RXD_PAR_STS_OFS 16'h3514
`define ME_HOST_ECC_OFS 16'h5bac
`define ME_PP_EN_OFS 16'h5f54
`define ME_PP_STS_OFS 16'h5f58

// ==========================================================
// Field positions, masks and reset values
// ==========================================================
`define ME_PB_CNT_LSB 0
`define ME_PB_ECC_EN_BIT 16
`define ME_PB_CORR_BIT 26
`define ME_DESC_EVEN_MASK 13'h1555
`define ME_FLEX_LSB 0
`define ME_FLEX_MSB 8
`define ME_FLEX_ALL 9'h1ff
`define ME_FAT_LAN_BIT 0
`define ME_FAT_DMA_BIT 3
`define ME_FATAL_MASK_RST 4'hf
`define ME_PB_ECC_EN_RST 1'b1
`define ME_CNT_MAX 8'hff

`endif

// [rtl/mem_err_pkg.sv]
// Purpose: Types shared by the memory error block
// Assumes: Constants come from mem_err_regs.svh
// Notes: Bus request travels as one packed struct
package mem_err_pkg;
  `include "mem_err_regs.svh"

  // ==========================================================
  // Avalon-MM request bundle
  // ==========================================================
  typedef struct packed {
    logic read;                        // Read request
    logic write;                       // Write request
    logic [`ME_AW-1:0] address;        // Byte address
    logic [`ME_DW-1:0] writedata;      // Write data
    logic [3:0] byteenable;            // Byte lanes of a write
  } avs_req_t;

  // ==========================================================
  // Block state
  // ==========================================================
  typedef struct packed {
    logic ack;                         // Answer cycle of the bus
    logic [`ME_DW-1:0] rdata;          // Registered read data
    logic [`ME_FAT_W-1:0] fatal;       // Fatal flags
    logic [`ME_FAT_W-1:0] fmask;       // Fatal cause mask
    logic [`ME_DESC_W-1:0] txd_ctl;    // Tx descriptor check enables
    logic [`ME_DESC_W-1:0] rxd_ctl;    // Rx descriptor check enables
    logic [`ME_DESC_W-1:0] hd_ctl;     // Host data check enables
    logic [`ME_DESC_W-1:0] txd_sts;    // Tx descriptor parity flags
    logic [`ME_DESC_W-1:0] rxd_sts;    // Rx descriptor parity flags
    logic rx_ecc_en;                   // Rx buffer ECC on
    logic tx_ecc_en;                   // Tx buffer ECC on
    logic rx_corr;                     // Rx buffer correctable flag
    logic tx_corr;                     // Tx buffer correctable flag
    logic [1:0] host_ecc;              // Host bus command ECC flags
    logic [`ME_PP_W-1:0] pp_en;        // Port parity enables
    logic [`ME_PP_W-1:0] pp_sts;       // Port parity flags
    logic [`ME_IRQ_W-1:0] irq_sts;     // Interrupt status
    logic [`ME_IRQ_W-1:0] irq_mask;    // Interrupt mask
  } me_state_t;
endpackage : mem_err_pkg

// [rtl/sat_counter.sv]
// Purpose: Saturating event counter with clear
// Assumes: One increment per clock at most
// Notes: An increment in the clearing cycle leaves a count of one
`timescale 1ns/1ps
module sat_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_inc,
  input wire logic i_clr,
  // Count
  output logic [W-1:0] o_count
);
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] MAX = {W{1'b1}};

  logic [W-1:0] cnt_r;   // Count value
  logic [W-1:0] cnt_nxt; // Next count

  // ==========================================================
  // Next count: clear, saturate, increment
  // ==========================================================
  always_comb begin
    cnt_nxt = cnt_r;
    if (i_clr) begin
      cnt_nxt = i_inc ? ONE : '0;
    end else if (i_inc && cnt_r != MAX) begin
      cnt_nxt = cnt_r + ONE;
    end
  end

  // Count register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_count = cnt_r;
endmodule : sat_counter

// [rtl/memory_error_reporting.sv]
// Purpose: Software view of parity and ECC errors of the internal memories
// Assumes: Event inputs are one-cycle pulses synchronous to i_clk
// Notes: Avalon-MM slave, every access answered after one wait cycle
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Functional notes
// RULE1: Four fatal flags latch, clear on read
// RULE2: Masked fatal flags drive fatal interrupt cause
// RULE3: Tx descriptor check enables on even bits
// RULE4: Buffer counters saturate at max, clear on read
// RULE5: Bit sixteen enables buffer ECC, default on
// RULE6: Bit 26 correctable flag, clears on read
// RULE7: Host bus command ECC flags, write one clears
// RULE8: Flex parity active only when field all ones
// RULE9: Six single enables for other port memories
// RULE10: Port parity status sticky until device reset
// RULE11: Software loads tables before enabling checks
// RULE12: Reserved bits read zero, writes ignored
// RULE13: Enabled port parity error sets port fatal
module memory_error_reporting
  import mem_err_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Avalon-MM slave
  input wire avs_req_t i_avs_req,
  output logic [`ME_DW-1:0] o_readdata,
  output logic o_waitrequest,
  // Error events from the memories
  input wire logic [`ME_FAT_W-1:0] i_fatal_event,
  input wire logic [`ME_DESC_W-1:0] i_txd_par_err,
  input wire logic [`ME_DESC_W-1:0] i_rxd_par_err,
  input wire logic i_rx_pb_corr_err,
  input wire logic i_tx_pb_corr_err,
  input wire logic i_host_wr_cmd_ecc_err,
  input wire logic i_host_rd_cmd_ecc_err,
  input wire logic [`ME_PP_W-1:0] i_port_par_err,
  // Enables to the memories
  output logic [`ME_DESC_W-1:0] o_txd_par_en,
  output logic [`ME_DESC_W-1:0] o_rxd_par_en,
  output logic [`ME_DESC_W-1:0] o_hd_par_en,
  output logic o_rx_pb_ecc_en,
  output logic o_tx_pb_ecc_en,
  output logic [`ME_PP_W-1:0] o_port_par_en,
  // Interrupts
  output logic o_fatal_error_interrupt_cause,
  output logic o_irq
);

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Byte-lane mask from byte enables
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Merge write data into a register under a lane and field mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] lm, input logic [31:0] fm);
    merge = (old & ~(lm & fm)) | (wd & lm & fm);
  endfunction : merge

  // ==========================================================
  // State and bus decode
  // ==========================================================
  me_state_t st_r;                 // Registered state
  me_state_t st_nxt;               // Next state
  logic req;                       // A request is on the bus
  logic commit;                    // Write or read side effect takes place
  logic [31:0] lm;                 // Lanes written
  logic [31:0] wd;                 // Write data
  logic [31:0] rd_val;             // Read data of the addressed register
  logic [`ME_CNT_W-1:0] rx_cnt;    // Rx buffer correctable count
  logic [`ME_CNT_W-1:0] tx_cnt;    // Tx buffer correctable count
  logic rd_rx_pb;                  // Read of rx buffer status commits
  logic rd_tx_pb;                  // Read of tx buffer status commits
  logic [`ME_PP_W-1:0] pp_set;     // Port parity detections that count
  logic [`ME_FAT_W-1:0] fat_set;   // Fatal flag sets this cycle
  logic [`ME_IRQ_W-1:0] irq_set;   // Interrupt events this cycle
  logic [`ME_DESC_W-1:0] txd_set;  // Tx descriptor flag sets
  logic [`ME_DESC_W-1:0] rxd_set;  // Rx descriptor flag sets

  assign req = i_avs_req.read | i_avs_req.write;
  assign commit = req & st_r.ack;
  assign lm = lane_mask(i_avs_req.byteenable);
  assign wd = i_avs_req.writedata;
  assign rd_rx_pb = commit & i_avs_req.read & (i_avs_req.address == `ME_RX_PB_ECC_OFS);
  assign rd_tx_pb = commit & i_avs_req.read & (i_avs_req.address == `ME_TX_PB_ECC_OFS);

  // ==========================================================
  // Event qualification
  // ==========================================================
  always_comb begin
    // Flex filter bits only when the whole field is set, others per bit
    pp_set = i_port_par_err & st_r.pp_en; // RULE9
    if (st_r.pp_en[`ME_FLEX_MSB:`ME_FLEX_LSB] != `ME_FLEX_ALL) begin
      pp_set[`ME_FLEX_MSB:`ME_FLEX_LSB] = '0; // RULE8
    end
    txd_set = i_txd_par_err & st_r.txd_ctl;
    rxd_set = i_rxd_par_err & st_r.rxd_ctl;
    fat_set = i_fatal_event;
    fat_set[`ME_FAT_LAN_BIT] = i_fatal_event[`ME_FAT_LAN_BIT] | (|pp_set); // RULE13
    irq_set = {(|txd_set) | (|rxd_set),
               i_host_wr_cmd_ecc_err | i_host_rd_cmd_ecc_err,
               i_tx_pb_corr_err, i_rx_pb_corr_err, |fat_set};
  end

  // ==========================================================
  // Read multiplexer, reserved bits zero
  // ==========================================================
  always_comb begin
    rd_val = '0; // RULE12
    unique case (i_avs_req.address)
      `ME_FATAL_FLAGS_OFS: rd_val[`ME_FAT_W-1:0] = st_r.fatal; // RULE1
      `ME_FATAL_MASK_OFS: rd_val[`ME_FAT_W-1:0] = st_r.fmask;
      `ME_IRQ_STATUS_OFS: rd_val[`ME_IRQ_W-1:0] = st_r.irq_sts;
      `ME_IRQ_MASK_OFS: rd_val[`ME_IRQ_W-1:0] = st_r.irq_mask;
      `ME_RX_PB_ECC_OFS: begin
        rd_val[`ME_CNT_W-1:0] = rx_cnt;
        rd_val[`ME_PB_ECC_EN_BIT] = st_r.rx_ecc_en;
        rd_val[`ME_PB_CORR_BIT] = st_r.rx_corr;
      end
      `ME_TX_PB_ECC_OFS: begin
        rd_val[`ME_CNT_W-1:0] = tx_cnt;
        rd_val[`ME_PB_ECC_EN_BIT] = st_r.tx_ecc_en;
        rd_val[`ME_PB_CORR_BIT] = st_r.tx_corr;
      end
      `ME_TXD_PAR_CTL_OFS: rd_val[`ME_DESC_W-1:0] = st_r.txd_ctl; // RULE3
      `ME_RXD_PAR_CTL_OFS: rd_val[`ME_DESC_W-1:0] = st_r.rxd_ctl;
      `ME_HD_PAR_CTL_OFS: rd_val[`ME_DESC_W-1:0] = st_r.hd_ctl;
      `ME_TXD_PAR_STS_OFS: rd_val[`ME_DESC_W-1:0] = st_r.txd_sts;
      `ME_RXD_PAR_STS_OFS: rd_val[`ME_DESC_W-1:0] = st_r.rxd_sts;
      `ME_HOST_ECC_OFS: rd_val[1:0] = st_r.host_ecc;
      `ME_PP_EN_OFS: rd_val[`ME_PP_W-1:0] = st_r.pp_en;
      `ME_PP_STS_OFS: rd_val[`ME_PP_W-1:0] = st_r.pp_sts; // RULE10
      default: rd_val = '0;
    endcase
  end

  // ==========================================================
  // Next state: bus, sticky flags, writes
  // ==========================================================
  always_comb begin
    st_nxt = st_r;
    // One wait cycle, read data captured before the answer
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.rdata = i_avs_req.read ? rd_val : '0;
    end
    // Clear-on-read and write effects at the answering edge
    if (commit && i_avs_req.read) begin
      unique case (i_avs_req.address)
        `ME_FATAL_FLAGS_OFS: st_nxt.fatal = st_r.fatal & ~st_r.rdata[`ME_FAT_W-1:0]; // RULE1
        `ME_RX_PB_ECC_OFS: st_nxt.rx_corr = 1'b0; // RULE6
        `ME_TX_PB_ECC_OFS: st_nxt.tx_corr = 1'b0; // RULE6
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    if (commit && i_avs_req.write) begin
      unique case (i_avs_req.address)
        `ME_FATAL_MASK_OFS: st_nxt.fmask = 4'(merge(32'(st_r.fmask), wd, lm, 32'hf));
        `ME_IRQ_STATUS_OFS: st_nxt.irq_sts = st_r.irq_sts & ~5'(wd & lm);
        `ME_IRQ_MASK_OFS: st_nxt.irq_mask = 5'(merge(32'(st_r.irq_mask), wd, lm, 32'h1f));
        `ME_RX_PB_ECC_OFS: begin
          if (i_avs_req.byteenable[2]) begin
            st_nxt.rx_ecc_en = wd[`ME_PB_ECC_EN_BIT]; // RULE5
          end
        end
        `ME_TX_PB_ECC_OFS: begin
          if (i_avs_req.byteenable[2]) begin
            st_nxt.tx_ecc_en = wd[`ME_PB_ECC_EN_BIT]; // RULE5
          end
        end
        `ME_TXD_PAR_CTL_OFS: begin
          st_nxt.txd_ctl = 13'(merge(32'(st_r.txd_ctl), wd, lm, 32'(`ME_DESC_EVEN_MASK))); // RULE3
        end
        `ME_RXD_PAR_CTL_OFS: begin
          st_nxt.rxd_ctl = 13'(merge(32'(st_r.rxd_ctl), wd, lm, 32'(`ME_DESC_EVEN_MASK)));
        end
        `ME_HD_PAR_CTL_OFS: begin
          st_nxt.hd_ctl = 13'(merge(32'(st_r.hd_ctl), wd, lm, 32'(`ME_DESC_EVEN_MASK)));
        end
        `ME_TXD_PAR_STS_OFS: st_nxt.txd_sts = st_r.txd_sts & ~13'(wd & lm);
        `ME_RXD_PAR_STS_OFS: st_nxt.rxd_sts = st_r.rxd_sts & ~13'(wd & lm);
        `ME_HOST_ECC_OFS: st_nxt.host_ecc = st_r.host_ecc & ~2'(wd & lm); // RULE7
        `ME_PP_EN_OFS: st_nxt.pp_en = 15'(merge(32'(st_r.pp_en), wd, lm, 32'h7fff));
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    // Hardware sets win over any clear in the same cycle
    st_nxt.fatal = st_nxt.fatal | fat_set; // RULE1
    st_nxt.rx_corr = st_nxt.rx_corr | i_rx_pb_corr_err; // RULE6
    st_nxt.tx_corr = st_nxt.tx_corr | i_tx_pb_corr_err; // RULE6
    st_nxt.txd_sts = st_nxt.txd_sts | txd_set;
    st_nxt.rxd_sts = st_nxt.rxd_sts | rxd_set;
    st_nxt.host_ecc = st_nxt.host_ecc | {i_host_rd_cmd_ecc_err, i_host_wr_cmd_ecc_err}; // RULE7
    st_nxt.pp_sts = st_r.pp_sts | pp_set; // RULE10
    st_nxt.irq_sts = st_nxt.irq_sts | irq_set;
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
      st_r.fmask <= `ME_FATAL_MASK_RST; // RULE2
      st_r.rx_ecc_en <= `ME_PB_ECC_EN_RST; // RULE5
      st_r.tx_ecc_en <= `ME_PB_ECC_EN_RST; // RULE5
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Correctable error counters
  // ==========================================================
  sat_counter #(.W(`ME_CNT_W)) u_rx_cnt (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_inc(i_rx_pb_corr_err), // RULE4
    .i_clr(rd_rx_pb),
    .o_count(rx_cnt)
  );

  sat_counter #(.W(`ME_CNT_W)) u_tx_cnt (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_inc(i_tx_pb_corr_err), // RULE4
    .i_clr(rd_tx_pb),
    .o_count(tx_cnt)
  );

  // ==========================================================
  // Outputs
  // ==========================================================
  assign o_readdata = st_r.rdata;
  assign o_waitrequest = req & ~st_r.ack;
  assign o_txd_par_en = st_r.txd_ctl;
  assign o_rxd_par_en = st_r.rxd_ctl;
  assign o_hd_par_en = st_r.hd_ctl;
  assign o_rx_pb_ecc_en = st_r.rx_ecc_en;
  assign o_tx_pb_ecc_en = st_r.tx_ecc_en;
  assign o_port_par_en = st_r.pp_en;
  assign o_fatal_error_interrupt_cause = |(st_r.fatal & st_r.fmask); // RULE2
  assign o_irq = |(st_r.irq_sts & st_r.irq_mask);

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence req_waiting;
    req && o_waitrequest;
  endsequence

  sequence rd_fatal_done;
    commit && i_avs_req.read && i_avs_req.address == `ME_FATAL_FLAGS_OFS;
  endsequence

  bus_answer_a: assert property (req_waiting |=> !o_waitrequest) // Bus access answered after one wait cycle
    else $error("bus request not answered after one wait cycle");
  fatal_clear_a: assert property (rd_fatal_done ##0 (fat_set == '0) |=>
                                  (st_r.fatal & $past(st_r.rdata[3:0])) == '0) // RULE1
    else $error("fatal flag not cleared by read");
  fatal_latch_a: assert property (fat_set[2] |=> st_r.fatal[2] [*2] or
                                  (st_r.fatal[2] ##0 rd_fatal_done)) // RULE1
    else $error("fatal flag did not latch");
  cause_mask_a: assert property (st_r.fatal[1] && st_r.fmask[1] |->
                                 o_fatal_error_interrupt_cause) // RULE2
    else $error("masked fatal flag missing from cause");
  cnt_sat_a: assert property (rx_cnt == `ME_CNT_MAX && !rd_rx_pb |=>
                              rx_cnt == `ME_CNT_MAX) // RULE4
    else $error("correctable counter wrapped");
  cnt_inc_a: assert property (i_tx_pb_corr_err && !rd_tx_pb && tx_cnt != `ME_CNT_MAX |=>
                              tx_cnt == $past(tx_cnt) + 8'h01) // RULE4
    else $error("correctable counter missed an increment");
  flex_gate_a: assert property (st_r.pp_en[8:0] != `ME_FLEX_ALL |=>
                                st_r.pp_sts[8:0] == $past(st_r.pp_sts[8:0])) // RULE8
    else $error("flex parity reported while not fully enabled");
  pp_sticky_a: assert property ((~st_r.pp_sts & $past(st_r.pp_sts)) == '0) // RULE10
    else $error("port parity status bit fell");
  lan_fatal_a: assert property (|(i_port_par_err & st_r.pp_en & 15'h7e00) |=>
                                st_r.fatal[0]) // RULE13
    else $error("port parity error did not set port fatal flag");
  host_ecc_a: assert property (st_r.host_ecc[0] && !i_host_wr_cmd_ecc_err && !commit |=>
                               st_r.host_ecc[0]) // RULE7
    else $error("host ECC flag lost without a write");
  rsvd_zero_a: assert property (!o_waitrequest && i_avs_req.read &&
                                i_avs_req.address == `ME_FATAL_MASK_OFS |->
                                o_readdata[31:4] == '0) // RULE12
    else $error("reserved bits read nonzero");
  ecc_en_rst_a: assert property ($rose(i_resetn) |-> st_r.rx_ecc_en && st_r.tx_ecc_en) // RULE5
    else $error("buffer ECC enable not set after reset");
endmodule : memory_error_reporting

// [bench/tb_memory_error_reporting.sv]
// Purpose: Self-checking bench of the memory error reporting block
// Assumes: One wait cycle per bus access, event inputs are one-cycle pulses
// Notes: Random masks and counts come from a fixed seed
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module tb_memory_error_reporting
  import mem_err_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic i_clk = 1'b0; // Bench clock
  logic i_resetn = 1'b0; // Reset, active low
  avs_req_t req = '0; // Bus request
  logic [3:0] fev = '0; // Fatal events
  logic [12:0] txe = '0, rxe = '0; // Descriptor parity events
  logic rxc = 1'b0, txc = 1'b0, hw = 1'b0, hr = 1'b0; // Single events
  logic [14:0] ppe = '0; // Port memory parity events
  logic [31:0] rdata, rd, n; // Read data, captured word, random word
  logic wr_wait, rxecc, txecc, cause, irq; // Single outputs
  logic [12:0] txen, rxen, hden; // Descriptor check enables
  logic [14:0] ppen; // Port parity enables
  int err_total = 0, cmp_count = 0, seed = 32'h2255fce5, i, cnt;

  // Clock at 20 MHz
  always #25 i_clk = ~i_clk;

  memory_error_reporting memory_error_reporting_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_req(req), .o_readdata(rdata),
    .o_waitrequest(wr_wait), .i_fatal_event(fev), .i_txd_par_err(txe),
    .i_rxd_par_err(rxe), .i_rx_pb_corr_err(rxc), .i_tx_pb_corr_err(txc),
    .i_host_wr_cmd_ecc_err(hw), .i_host_rd_cmd_ecc_err(hr), .i_port_par_err(ppe),
    .o_txd_par_en(txen), .o_rxd_par_en(rxen), .o_hd_par_en(hden),
    .o_rx_pb_ecc_en(rxecc), .o_tx_pb_ecc_en(txecc), .o_port_par_en(ppen),
    .o_fatal_error_interrupt_cause(cause), .o_irq(irq)
  );

  // ==========================================================
  // Bus and event helpers
  // ==========================================================
  // One Avalon access, held until waitrequest is seen low
  task automatic acc(input logic r, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    k = 0;
    @(posedge i_clk);
    req <= '{read: r, write: !r, address: a, writedata: d, byteenable: be};
    // Sample waitrequest and read data at the rising edge, release right after it
    do begin
      @(posedge i_clk);
      k++;
    end while (wr_wait !== 1'b0 && k < 20);
    if (k >= 20) err_total++;
    rd = rdata;
    req <= '0;
  endtask : acc

  // Full word write
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b0, a, d, 4'hf);
  endtask : wr

  // Read and compare
  task automatic chk_rd(input logic [15:0] a, input logic [31:0] e);
    acc(1'b1, a, '0, 4'hf);
    `CHK(rd, e)
  endtask : chk_rd

  // Drop every event input at the next edge
  task automatic ev_clear();
    @(posedge i_clk);
    {fev, txe, rxe, rxc, txc, hw, hr, ppe} <= '0;
  endtask : ev_clear

  // Expected buffer word: ECC on, flag set, saturating count
  function automatic logic [31:0] exp_pb(input int c);
    return 32'h04010000 | ((c > 255) ? 32'h000000ff : 32'(c));
  endfunction : exp_pb

  // Verdict and end of run
  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Watchdog
  // ==========================================================
  initial begin
    #(5000 * 50);
    err_total++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    // Reset values and an unmapped place
    chk_rd(`ME_FATAL_MASK_OFS, 32'h0000000f);
    chk_rd(`ME_RX_PB_ECC_OFS, 32'h00010000);
    chk_rd(`ME_TX_PB_ECC_OFS, 32'h00010000);
    chk_rd(`ME_PP_EN_OFS, 32'h0);
    chk_rd(16'h1000, 32'h0);
    // Only even descriptor enables stick
    for (i = 0; i < 3; i++) begin
      wr(16'(`ME_TXD_PAR_CTL_OFS + 4 * i), 32'hffffffff);
      chk_rd(16'(`ME_TXD_PAR_CTL_OFS + 4 * i), 32'h00001555);
    end
    `CHK({txen, rxen, hden}, {3{13'h1555}})
    // Each fatal flag under a random mask
    for (i = 0; i < 4; i++) begin
      n = $random(seed);
      wr(`ME_FATAL_MASK_OFS, n);
      chk_rd(`ME_FATAL_MASK_OFS, n & 32'hf);
      @(posedge i_clk);
      fev <= 4'h1 << i;
      ev_clear();
      @(negedge i_clk);
      `CHK(cause, n[i])
      chk_rd(`ME_FATAL_FLAGS_OFS, 32'h1 << i);
      chk_rd(`ME_FATAL_FLAGS_OFS, 32'h0);
      `CHK(cause, 1'b0)
    end
    // Back-to-back correctable errors, random count then saturation
    for (i = 0; i < 2; i++) begin
      cnt = (i == 0) ? (($random(seed) & 32'hf) + 1) : 260;
      repeat (cnt) begin
        @(posedge i_clk);
        rxc <= 1'b1;
        txc <= 1'b1;
      end
      ev_clear();
      chk_rd(`ME_RX_PB_ECC_OFS, exp_pb(cnt));
      chk_rd(`ME_TX_PB_ECC_OFS, exp_pb(cnt));
      chk_rd(`ME_RX_PB_ECC_OFS, 32'h00010000);
    end
    // ECC enable follows byte lane 2 only
    acc(1'b0, `ME_RX_PB_ECC_OFS, 32'h0, 4'hb);
    `CHK(rxecc, 1'b1)
    acc(1'b0, `ME_RX_PB_ECC_OFS, 32'h0, 4'h4);
    wr(`ME_TX_PB_ECC_OFS, 32'hfbfeffff);
    @(negedge i_clk);
    `CHK({rxecc, txecc}, 2'b00)
    chk_rd(`ME_TX_PB_ECC_OFS, 32'h0);
    // Host bus command errors, write one clears
    @(posedge i_clk);
    hw <= 1'b1;
    hr <= 1'b1;
    ev_clear();
    chk_rd(`ME_HOST_ECC_OFS, 32'h3);
    wr(`ME_HOST_ECC_OFS, 32'h1);
    chk_rd(`ME_HOST_ECC_OFS, 32'h2);
    // Flex field one short of all ones, singles on
    wr(`ME_PP_EN_OFS, 32'hffff7eff);
    chk_rd(`ME_PP_EN_OFS, 32'h00007eff);
    `CHK(ppen, 15'h7eff)
    @(posedge i_clk);
    ppe <= 15'h01ff;
    ev_clear();
    chk_rd(`ME_PP_STS_OFS, 32'h0);
    chk_rd(`ME_FATAL_FLAGS_OFS, 32'h0);
    for (i = 9; i < 15; i++) begin
      @(posedge i_clk);
      ppe <= 15'h1 << i;
      ev_clear();
      chk_rd(`ME_PP_STS_OFS, ((32'h1 << (i + 1)) - 32'h1) & 32'h7e00);
      chk_rd(`ME_FATAL_FLAGS_OFS, 32'h1);
    end
    wr(`ME_PP_EN_OFS, 32'h000001ff);
    @(posedge i_clk);
    ppe <= 15'h01ff;
    ev_clear();
    wr(`ME_PP_STS_OFS, 32'h0);
    chk_rd(`ME_PP_STS_OFS, 32'h7fff);
    chk_rd(`ME_FATAL_FLAGS_OFS, 32'h1);
    // Interrupt raised by an unmasked event, then cleared
    wr(`ME_IRQ_MASK_OFS, 32'h2);
    wr(`ME_IRQ_STATUS_OFS, 32'h1f);
    @(negedge i_clk);
    `CHK(irq, 1'b0)
    @(posedge i_clk);
    rxc <= 1'b1;
    ev_clear();
    repeat (3) @(negedge i_clk);
    `CHK(irq, 1'b1)
    wr(`ME_IRQ_STATUS_OFS, 32'h2);
    @(negedge i_clk);
    `CHK(irq, 1'b0)
    // Port parity status clears on a mid-run reset
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk_rd(`ME_PP_STS_OFS, 32'h0);
    give_verdict();
  end
endmodule : tb_memory_error_reporting
